// file: hw/isc_pkg.sv
/*
  Shared constants and types of the interrupt and stack control block.
  Assumes a 4-bit core sequencer and seven on-chip event sources.
*/
package isc_pkg;
  localparam int ISC_SRC_N = 7;
  localparam int ISC_PC_W = 14;
  localparam int ISC_LVL_W = 4;
  localparam int ISC_SP_W = 10;
  localparam int ISC_DEPTH = 16;

  // Stack pointer: fixed top bits, level index, fixed low bits
  localparam logic [3:0] ISC_SP_TOP_BITS = 4'hF;
  localparam logic [1:0] ISC_SP_LOW_BITS = 2'h3;
  localparam logic [ISC_LVL_W-1:0] ISC_LVL_TOP = 4'hF;
  localparam logic [ISC_LVL_W-1:0] ISC_LVL_ONE = 4'h1;

  localparam logic [ISC_PC_W-1:0] ISC_PC_RESET = 14'h0000;
  localparam logic [ISC_PC_W-1:0] ISC_PC_ONE = 14'h0001;
  localparam logic ISC_COND_RESET = 1'b1;
  localparam logic [ISC_SRC_N-1:0] ISC_MASK_RESET = 7'h7F;
  localparam logic [ISC_SRC_N-1:0] ISC_PEND_RESET = 7'h00;

  // Vector of source i sits at VEC_BASE + VEC_STEP * i
  localparam logic [ISC_PC_W-1:0] ISC_VEC_BASE = 14'h0002;
  localparam logic [ISC_PC_W-1:0] ISC_VEC_STEP = 14'h0002;

  // Source order doubles as fixed priority, index 0 highest
  localparam int ISC_SRC_EXT0 = 0;
  localparam int ISC_SRC_EXT1 = 1;
  localparam int ISC_SRC_TMRA = 2;
  localparam int ISC_SRC_TMRB = 3;
  localparam int ISC_SRC_TMRC = 4;
  localparam int ISC_SRC_ADC = 5;
  localparam int ISC_SRC_SER = 6;

  // Control nibbles $000-$003 as one 16-bit image, plus the stack reinit write bit at bit 16
  localparam int ISC_BIT_GATE = 0;
  localparam int ISC_BIT_PEND0 = 2;
  localparam int ISC_BIT_MASK0 = 3;
  localparam int ISC_BIT_STACK_REINIT = 16;

  // AXI4-Lite byte addresses
  localparam logic [7:0] ISC_ADDR_CTRL = 8'h00;
  localparam logic [7:0] ISC_ADDR_BIT_SET = 8'h04;
  localparam logic [7:0] ISC_ADDR_BIT_CLR = 8'h08;
  localparam logic [7:0] ISC_ADDR_STATUS = 8'h0C;
  localparam logic [1:0] ISC_RESP_OKAY = 2'h0;
  localparam logic [1:0] ISC_RESP_SLVERR = 2'h2;

  // Status word field positions
  localparam int ISC_STAT_PC_LSB = 0;
  localparam int ISC_STAT_SP_LSB = 16;
  localparam int ISC_STAT_COND_BIT = 28;
  localparam int ISC_STAT_OVF_BIT = 29;

  typedef enum logic [2:0] {ISC_IDLE, ISC_ENTRY1, ISC_ENTRY2, ISC_ENTRY3, ISC_RETURN} isc_fsm_t;

  typedef struct packed {
    logic [ISC_PC_W-1:0] pc;
    logic cond;
    logic ovf;
  } isc_frame_t;

  typedef struct packed {
    logic [7:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [7:0] araddr;
    logic arvalid;
    logic rready;
  } isc_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } isc_axi_rsp_t;
endpackage : isc_pkg

// file: hw/isc_stack_mem.sv
/*
  Stack frame memory, one frame per nesting level, registered read data.
  Assumes the caller never reads and writes the same entry in one cycle.
*/
module isc_stack_mem
  import isc_pkg::*;
#(
  parameter int DEPTH = ISC_DEPTH,
  parameter int AW = ISC_LVL_W
)
(
  input wire logic aclk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire isc_frame_t wr_data,
  input wire logic [AW-1:0] rd_addr,
  output isc_frame_t rd_data_reg
);
  isc_frame_t mem [DEPTH];

  always_ff @(posedge aclk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
    rd_data_reg <= mem[rd_addr];
  end
endmodule : isc_stack_mem

// file: hw/isc_prio_enc.sv
/*
  Fixed-priority selector of the winning interrupt source and its vector.
  Assumes request bit 0 has the highest priority.
*/
module isc_prio_enc
  import isc_pkg::*;
#(
  parameter int N = ISC_SRC_N
)
(
  input wire logic [N-1:0] request,
  output logic hit,
  output logic [ISC_PC_W-1:0] vector
);
  always_comb
  begin
    hit = 1'b0;
    vector = ISC_PC_RESET;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (request[i])
      begin
        hit = 1'b1;
        vector = ISC_PC_W'(ISC_VEC_BASE + ISC_VEC_STEP * ISC_PC_W'(i));
      end
    end
  end
endmodule : isc_prio_enc

// file: hw/isc_core.sv
/*
  Interrupt and stack control: pending flags, masks, global gate, entry
  sequence, program counter, stack pointer, condition and overflow flags,
  with an AXI4-Lite register window.
  Assumes a core sequencer that issues one-cycle instruction pulses and
  waits while seq_stall is high.
*/
// Decided for this implementation: the register addresses and register access over AXI4-Lite.
module isc_core
  import isc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire isc_axi_req_t axi_req,
  output isc_axi_rsp_t axi_rsp,
  input wire logic [ISC_SRC_N-1:0] src_event,
  input wire logic instr_done,
  input wire logic pc_step,
  input wire logic pc_jump,
  input wire logic [ISC_PC_W-1:0] jump_target,
  input wire logic call_op,
  input wire logic cond_fetch,
  input wire logic cond_update,
  input wire logic cond_value,
  input wire logic carry_we,
  input wire logic carry_value,
  input wire logic subroutine_return,
  input wire logic return_from_irq,
  output logic [ISC_PC_W-1:0] pc,
  output logic [ISC_SP_W-1:0] sp,
  output logic branch_condition_flag,
  output logic alu_overflow_bit,
  output logic global_irq_gate,
  output logic seq_stall
);
  typedef struct packed {
    isc_fsm_t fsm;
    logic ret_irq;
    logic [ISC_PC_W-1:0] pc;
    logic [ISC_LVL_W-1:0] lvl;
    logic cond;
    logic ovf;
    logic gate;
    logic [ISC_SRC_N-1:0] source_mask_bit;
    logic [ISC_SRC_N-1:0] pend;
    logic [ISC_PC_W-1:0] vec;
    logic stall;
    logic aw_held;
    logic [7:0] awaddr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    isc_axi_rsp_t rsp;
  } isc_state_t;

  isc_state_t state_reg;
  isc_state_t state_next;
  logic irq_hit;
  logic [ISC_PC_W-1:0] irq_vector;
  logic [ISC_SRC_N-1:0] irq_request;
  logic mem_wr_en;
  logic [ISC_LVL_W-1:0] mem_wr_addr;
  isc_frame_t mem_wr_data;
  isc_frame_t mem_rd_data;
  logic [15:0] ctrl_image;
  logic [31:0] wr_word;

  assign irq_request = state_reg.pend & ~state_reg.source_mask_bit;

  isc_prio_enc #(
    .N(ISC_SRC_N)
  ) u_prio (
    .request(irq_request),
    .hit(irq_hit),
    .vector(irq_vector)
  );

  isc_stack_mem #(
    .DEPTH(ISC_DEPTH),
    .AW(ISC_LVL_W)
  ) u_stack (
    .aclk(aclk),
    .wr_en(mem_wr_en),
    .wr_addr(mem_wr_addr),
    .wr_data(mem_wr_data),
    .rd_addr(ISC_LVL_W'(state_reg.lvl + ISC_LVL_ONE)),
    .rd_data_reg(mem_rd_data)
  );

  // Control nibble image: gate, then pending/mask pairs per source
  always_comb
  begin
    ctrl_image = '0;
    ctrl_image[ISC_BIT_GATE] = state_reg.gate;
    for (int i = 0; i < ISC_SRC_N; i++)
    begin
      ctrl_image[ISC_BIT_PEND0 + 2 * i] = state_reg.pend[i];
      ctrl_image[ISC_BIT_MASK0 + 2 * i] = state_reg.source_mask_bit[i];
    end
  end

  // Byte-lane masked write word
  assign wr_word = state_reg.wdata & {{8{state_reg.wstrb[3]}}, {8{state_reg.wstrb[2]}}, {8{state_reg.wstrb[1]}},
    {8{state_reg.wstrb[0]}}};

  always_comb
  begin
    logic [ISC_SRC_N-1:0] set_mask;
    logic [ISC_SRC_N-1:0] clr_mask;
    logic [ISC_SRC_N-1:0] clr_pend;
    set_mask = '0;
    clr_mask = '0;
    clr_pend = '0;
    state_next = state_reg;
    mem_wr_en = 1'b0;
    mem_wr_addr = state_reg.lvl;
    mem_wr_data = '{pc: state_reg.pc, cond: state_reg.cond, ovf: state_reg.ovf};

    // AXI4-Lite write channel: address and data in either order
    if (axi_req.awvalid && state_reg.rsp.awready)
    begin
      state_next.aw_held = 1'b1;
      state_next.awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && state_reg.rsp.wready)
    begin
      state_next.w_held = 1'b1;
      state_next.wdata = axi_req.wdata;
      state_next.wstrb = axi_req.wstrb;
    end
    if (state_reg.rsp.bvalid && axi_req.bready)
    begin
      state_next.rsp.bvalid = 1'b0;
    end
    if (state_reg.aw_held && state_reg.w_held && !state_reg.rsp.bvalid)
    begin
      state_next.aw_held = 1'b0;
      state_next.w_held = 1'b0;
      state_next.rsp.bvalid = 1'b1;
      state_next.rsp.bresp = ISC_RESP_OKAY;
      if (state_reg.awaddr == ISC_ADDR_BIT_SET)
      begin
        state_next.gate = state_reg.gate | wr_word[ISC_BIT_GATE];
        for (int i = 0; i < ISC_SRC_N; i++)
        begin
          set_mask[i] = wr_word[ISC_BIT_MASK0 + 2 * i];
        end
      end
      else if (state_reg.awaddr == ISC_ADDR_BIT_CLR)
      begin
        if (wr_word[ISC_BIT_GATE])
        begin
          state_next.gate = 1'b0;
        end
        for (int i = 0; i < ISC_SRC_N; i++)
        begin
          clr_pend[i] = wr_word[ISC_BIT_PEND0 + 2 * i];
          clr_mask[i] = wr_word[ISC_BIT_MASK0 + 2 * i];
        end
        if (wr_word[ISC_BIT_STACK_REINIT])
        begin
          state_next.lvl = ISC_LVL_TOP;
        end
      end
      else if (state_reg.awaddr != ISC_ADDR_CTRL && state_reg.awaddr != ISC_ADDR_STATUS)
      begin
        state_next.rsp.bresp = ISC_RESP_SLVERR;
      end
    end
    state_next.rsp.awready = !state_next.aw_held && !state_next.rsp.bvalid;
    state_next.rsp.wready = !state_next.w_held && !state_next.rsp.bvalid;

    // AXI4-Lite read channel
    if (state_reg.rsp.rvalid && axi_req.rready)
    begin
      state_next.rsp.rvalid = 1'b0;
    end
    if (axi_req.arvalid && state_reg.rsp.arready)
    begin
      state_next.rsp.rvalid = 1'b1;
      state_next.rsp.rresp = ISC_RESP_OKAY;
      state_next.rsp.rdata = '0;
      if (axi_req.araddr == ISC_ADDR_CTRL)
      begin
        state_next.rsp.rdata[15:0] = ctrl_image;
      end
      else if (axi_req.araddr == ISC_ADDR_STATUS)
      begin
        state_next.rsp.rdata[ISC_STAT_PC_LSB +: ISC_PC_W] = state_reg.pc;
        state_next.rsp.rdata[ISC_STAT_SP_LSB +: ISC_SP_W] = sp;
        state_next.rsp.rdata[ISC_STAT_COND_BIT] = state_reg.cond;
        state_next.rsp.rdata[ISC_STAT_OVF_BIT] = state_reg.ovf;
      end
      else if (axi_req.araddr != ISC_ADDR_BIT_SET && axi_req.araddr != ISC_ADDR_BIT_CLR)
      begin
        state_next.rsp.rresp = ISC_RESP_SLVERR;
      end
    end
    state_next.rsp.arready = !state_next.rsp.rvalid;

    // Instruction effects in ISC_IDLE and in the first entry step ISC_ENTRY1
    if (state_reg.fsm == ISC_IDLE || state_reg.fsm == ISC_ENTRY1)
    begin
      if (carry_we)
      begin
        state_next.ovf = carry_value;
      end
      if (cond_update)
      begin
        state_next.cond = cond_value;
      end
      if (cond_fetch)
      begin
        state_next.cond = 1'b1;
      end
      if (pc_jump)
      begin
        state_next.pc = jump_target;
      end
      else if (pc_step)
      begin
        state_next.pc = state_reg.pc + ISC_PC_ONE;
      end
    end

    case (state_reg.fsm)
      ISC_IDLE:
      begin
        if (instr_done && state_reg.gate && irq_hit)
        begin
          state_next.fsm = ISC_ENTRY1;
          state_next.vec = irq_vector;
        end
        else if (call_op)
        begin
          mem_wr_en = 1'b1;
          mem_wr_data.pc = state_reg.pc + ISC_PC_ONE;
          state_next.lvl = state_reg.lvl - ISC_LVL_ONE;
          state_next.pc = jump_target;
        end
        else if (return_from_irq || subroutine_return)
        begin
          state_next.fsm = ISC_RETURN;
          state_next.ret_irq = return_from_irq;
        end
      end
      ISC_ENTRY1:
      begin
        state_next.fsm = ISC_ENTRY2;
      end
      ISC_ENTRY2:
      begin
        state_next.gate = 1'b0;
        mem_wr_en = 1'b1;
        state_next.fsm = ISC_ENTRY3;
      end
      ISC_ENTRY3:
      begin
        state_next.lvl = state_reg.lvl - ISC_LVL_ONE;
        state_next.pc = state_reg.vec;
        state_next.fsm = ISC_IDLE;
      end
      ISC_RETURN:
      begin
        state_next.pc = mem_rd_data.pc;
        state_next.lvl = state_reg.lvl + ISC_LVL_ONE;
        if (state_reg.ret_irq)
        begin
          state_next.cond = mem_rd_data.cond;
          state_next.ovf = mem_rd_data.ovf;
          state_next.gate = 1'b1;
        end
        state_next.fsm = ISC_IDLE;
      end
      default:
      begin
        state_next.fsm = ISC_IDLE;
      end
    endcase

    // Pending flags: hardware set wins over software clear; software never sets them
    state_next.pend = (state_reg.pend & ~clr_pend) | src_event;
    state_next.source_mask_bit = (state_reg.source_mask_bit & ~clr_mask) | set_mask;
    state_next.stall = state_next.fsm != ISC_IDLE;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg <= '0;
      state_reg.fsm <= ISC_IDLE;
      state_reg.pc <= ISC_PC_RESET;
      state_reg.lvl <= ISC_LVL_TOP;
      state_reg.cond <= ISC_COND_RESET;
      state_reg.gate <= 1'b0;
      state_reg.pend <= ISC_PEND_RESET;
      state_reg.source_mask_bit <= ISC_MASK_RESET;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign axi_rsp = state_reg.rsp;
  assign pc = state_reg.pc;
  assign sp = {ISC_SP_TOP_BITS, state_reg.lvl, ISC_SP_LOW_BITS};
  assign branch_condition_flag = state_reg.cond;
  assign alu_overflow_bit = state_reg.ovf;
  assign global_irq_gate = state_reg.gate;
  assign seq_stall = state_reg.stall;
endmodule : isc_core

// file: tb/isc_core_chk.sv
/*
  Port checks of the interrupt and stack control block.
  Assumes one clock and an active-low synchronous reset.
*/
module isc_core_chk
  import isc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic instr_done,
  input wire logic pc_step,
  input wire logic pc_jump,
  input wire logic [ISC_PC_W-1:0] jump_target,
  input wire logic call_op,
  input wire logic cond_fetch,
  input wire logic subroutine_return,
  input wire logic return_from_irq,
  input wire logic [ISC_PC_W-1:0] pc,
  input wire logic [ISC_SP_W-1:0] sp,
  input wire logic branch_condition_flag,
  input wire logic alu_overflow_bit,
  input wire logic global_irq_gate,
  input wire logic seq_stall
);
  timeunit 1ns;
  timeprecision 1ps;
  logic free;
  logic ret_any;
  // Sequencer request that no entry can pre-empt
  assign free = !seq_stall && !(instr_done && global_irq_gate);
  assign ret_any = subroutine_return || return_from_irq;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence entry_s;
    !seq_stall ##1 seq_stall [*2];
  endsequence
  sequence ret_s;
    free && !call_op && ret_any ##1 seq_stall;
  endsequence
  AST_RESET:
    assert property ($rose(aresetn) |-> pc == ISC_PC_RESET && sp == 10'h3FF && branch_condition_flag
      && !alu_overflow_bit && !global_irq_gate && !seq_stall) else $error("reset values wrong");
  AST_SP_FIXED:
    assert property (sp[9:6] == ISC_SP_TOP_BITS && sp[1:0] == ISC_SP_LOW_BITS) else $error("sp fixed bits");
  AST_CALL:
    assert property (free && call_op |=> sp[5:2] == $past(sp[5:2]) - 4'h1 && pc == $past(jump_target))
    else $error("call push wrong");
  AST_RET_POP:
    assert property (ret_s |=> !seq_stall && sp[5:2] == $past(sp[5:2], 2) + 4'h1) else $error("return pop wrong");
  AST_SUB_KEEP:
    assert property (free && !call_op && subroutine_return && !return_from_irq |=> ##1
      $stable(branch_condition_flag) && $stable(alu_overflow_bit)) else $error("plain return moved flags");
  AST_IRET_GATE:
    assert property (free && !call_op && return_from_irq && !subroutine_return |-> ##2 global_irq_gate)
    else $error("gate not reopened");
  AST_ENTRY:
    assert property (entry_s |-> ##1 seq_stall && !global_irq_gate ##1 !seq_stall) else $error("entry steps wrong");
  AST_VECTOR:
    assert property (entry_s |-> ##2 pc >= ISC_VEC_BASE && pc <= 14'h000E && !pc[0]
      && sp[5:2] == $past(sp[5:2], 3) - 4'h1) else $error("vector or push wrong");
  AST_FETCH:
    assert property (free && cond_fetch && !ret_any |=> branch_condition_flag) else $error("fetch flag not 1");
  AST_STEP:
    assert property (free && pc_step && !pc_jump && !call_op && !ret_any |=> pc == $past(pc) + ISC_PC_ONE)
    else $error("pc step wrong");
endmodule : isc_core_chk

bind isc_core isc_core_chk isc_core_chk_i (
  .aclk, .aresetn, .instr_done, .pc_step, .pc_jump, .jump_target, .call_op, .cond_fetch,
  .subroutine_return, .return_from_irq, .pc, .sp, .branch_condition_flag, .alu_overflow_bit,
  .global_irq_gate, .seq_stall
);

// file: tb/isc_src_model.sv
/*
  Event source model: pins, timers, serial and converter.
  Assumes the bench asks for events with a one-cycle fire mask.
*/
module isc_src_model
  import isc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic slow,
  input wire logic [ISC_SRC_N-1:0] fire,
  output logic [ISC_SRC_N-1:0] src_event
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [ISC_SRC_N-1:0] late_reg;
  // Slow mode adds one cycle of lag
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      late_reg <= ISC_PEND_RESET;
      src_event <= ISC_PEND_RESET;
    end
    else
    begin
      late_reg <= fire;
      src_event <= slow ? late_reg : fire;
    end
  end
endmodule : isc_src_model

// file: tb/isc_core_bench.sv
/*
  Self-checking bench: reset, register window, priority, returns, stack.
  Assumes the design, its checker and the event model are compiled first.
*/
module isc_core_bench
  import isc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [8:0] DONE = 9'h100;
  localparam logic [8:0] STEP = 9'h080;
  localparam logic [8:0] JUMP = 9'h040;
  localparam logic [8:0] CALL = 9'h020;
  localparam logic [8:0] FETCH = 9'h010;
  localparam logic [8:0] UPD = 9'h00C;
  localparam logic [8:0] SRET = 9'h002;
  localparam logic [8:0] IRET = 9'h001;
  logic aclk;
  logic aresetn;
  isc_axi_req_t req;
  isc_axi_rsp_t rsp;
  logic [ISC_SRC_N-1:0] fire;
  logic [ISC_SRC_N-1:0] src_event;
  logic slow;
  logic [8:0] sq;
  logic [ISC_PC_W-1:0] tgt;
  logic cval;
  logic kval;
  logic [ISC_PC_W-1:0] pc;
  logic [ISC_SP_W-1:0] sp;
  logic flag;
  logic carry;
  logic gate;
  logic stall;
  logic [31:0] rd;
  logic [1:0] rs;
  int errors;
  int total_checks;
  int cycles;

  isc_core isc_core_i (
    .aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp), .src_event(src_event),
    .instr_done(sq[8]), .pc_step(sq[7]), .pc_jump(sq[6]), .jump_target(tgt), .call_op(sq[5]),
    .cond_fetch(sq[4]), .cond_update(sq[3]), .cond_value(cval), .carry_we(sq[2]), .carry_value(kval),
    .subroutine_return(sq[1]), .return_from_irq(sq[0]), .pc(pc), .sp(sp),
    .branch_condition_flag(flag), .alu_overflow_bit(carry), .global_irq_gate(gate), .seq_stall(stall)
  );
  isc_src_model isc_src_model_i (
    .aclk(aclk), .aresetn(aresetn), .slow(slow), .fire(fire), .src_event(src_event)
  );

  initial
  begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      errors++;
      close_out();
    end
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out

  // bready and rready stay high, so no strobe toggles between transfers
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    req.awaddr <= a;
    req.wdata <= d;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (rsp.awready)
        req.awvalid <= 1'b0;
      if (rsp.wready)
        req.wvalid <= 1'b0;
    end
    while (!rsp.bvalid);
    rs = rsp.bresp;
  endtask : wr

  task automatic rdw(input logic [7:0] a);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (rsp.arready)
        req.arvalid <= 1'b0;
    end
    while (!rsp.rvalid);
    rd = rsp.rdata;
    rs = rsp.rresp;
  endtask : rdw

  task automatic go(input logic [8:0] m);
    sq <= m;
    @(posedge aclk);
    sq <= 9'h000;
    @(posedge aclk);
  endtask : go

  task automatic settle();
    for (int n = 0; n < 10 && stall; n++)
      @(posedge aclk);
  endtask : settle

  task automatic t_reset();
    chk("pc", ISC_PC_RESET, pc);
    chk("sp", 32'h3FF, sp);
    chk("flag", 32'h1, flag);
    chk("gate", 32'h0, gate);
    rdw(ISC_ADDR_CTRL);
    chk("ctrl", 32'hAAA8, rd);
    $display("test reset done");
  endtask : t_reset

  task automatic t_window();
    wr(ISC_ADDR_BIT_SET, 32'h5555);
    chk("bresp", ISC_RESP_OKAY, rs);
    rdw(ISC_ADDR_CTRL);
    chk("ctrl", 32'hAAA9, rd);
    chk("rresp", ISC_RESP_OKAY, rs);
    chk("gate", 32'h1, gate);
    rdw(ISC_ADDR_STATUS);
    chk("status", 32'h13FF0000, rd);
    rdw(8'h10);
    chk("resp", ISC_RESP_SLVERR, rs);
    wr(8'h10, 32'hFFFF);
    chk("bresp", ISC_RESP_SLVERR, rs);
    rdw(ISC_ADDR_CTRL);
    chk("ctrl", 32'hAAA9, rd);
    $display("test window done");
  endtask : t_window

  task automatic t_prio();
    wr(ISC_ADDR_BIT_CLR, 32'hAAA8);
    fire <= 7'h7F;
    @(posedge aclk);
    fire <= 7'h00;
    for (int i = 0; i < ISC_SRC_N; i++)
    begin
      tgt <= 14'h0100;
      cval <= 1'b0;
      kval <= 1'b1;
      go(JUMP | UPD);
      go(DONE);
      settle();
      chk("vector", 32'h2 + 32'h2 * i, pc);
      chk("sp", 32'h3FB, sp);
      chk("gate", 32'h0, gate);
      cval <= 1'b1;
      kval <= 1'b0;
      go(UPD);
      wr(ISC_ADDR_BIT_CLR, 32'h4 << (2 * i));
      go(IRET);
      settle();
      chk("pc", 32'h100, pc);
      chk("flags", 32'h1, {flag, carry});
      chk("gate", 32'h1, gate);
    end
    $display("test priority done");
  endtask : t_prio

  task automatic t_sub();
    tgt <= 14'h0200;
    go(JUMP);
    go(STEP);
    chk("pc", 32'h201, pc);
    tgt <= 14'h0300;
    cval <= 1'b0;
    kval <= 1'b1;
    go(CALL | UPD);
    chk("pc", 32'h300, pc);
    chk("sp", 32'h3FB, sp);
    cval <= 1'b1;
    kval <= 1'b0;
    go(UPD);
    go(SRET);
    settle();
    chk("pc", 32'h202, pc);
    chk("sp", 32'h3FF, sp);
    chk("flags", 32'h2, {flag, carry});
    cval <= 1'b0;
    go(UPD);
    go(STEP);
    chk("flag", 32'h0, flag);
    go(FETCH);
    chk("flag", 32'h1, flag);
    $display("test subroutine done");
  endtask : t_sub

  task automatic t_stack();
    tgt <= 14'h0400;
    repeat (15) go(CALL);
    chk("sp", 32'h3C3, sp);
    go(CALL);
    chk("sp", 32'h3FF, sp);
    repeat (2) go(CALL);
    chk("sp", 32'h3F7, sp);
    wr(ISC_ADDR_BIT_CLR, 32'h10000);
    chk("sp", 32'h3FF, sp);
    $display("test stack done");
  endtask : t_stack

  task automatic t_mask();
    slow <= 1'b1;
    wr(ISC_ADDR_BIT_SET, 32'h201);
    fire <= 7'h08;
    @(posedge aclk);
    fire <= 7'h00;
    repeat (3) @(posedge aclk);
    rdw(ISC_ADDR_CTRL);
    chk("ctrl", 32'h301, rd);
    go(DONE);
    chk("stall", 32'h0, stall);
    wr(ISC_ADDR_BIT_CLR, 32'h201);
    go(DONE);
    chk("stall", 32'h0, stall);
    wr(ISC_ADDR_BIT_SET, 32'h1);
    go(DONE);
    settle();
    chk("vector", 32'h8, pc);
    $display("test mask done");
  endtask : t_mask

  task automatic t_rereset();
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    $display("test mid-run reset done");
  endtask : t_rereset

  initial
  begin
    aresetn = 1'b0;
    req = '0;
    req.wstrb = 4'hF;
    req.bready = 1'b1;
    req.rready = 1'b1;
    fire = 7'h00;
    slow = 1'b0;
    sq = 9'h000;
    tgt = 14'h0000;
    cval = 1'b0;
    kval = 1'b0;
    errors = 0;
    total_checks = 0;
    cycles = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_window();
    t_prio();
    t_sub();
    t_stack();
    t_mask();
    t_rereset();
    close_out();
  end
endmodule : isc_core_bench
